// File: design/fe_seq_pkg.sv
package fe_seq_pkg;
  // instruction word layout
  localparam int INSTR_W = 22;
  localparam int RESULT_W = 25;
  localparam int IMEM_AW = 8;
  localparam int RMEM_AW = 8;
  localparam int TYPE_HI = 21;
  localparam int TYPE_LO = 20;
  localparam int ADDR_W = 20;
  localparam int FAIL_BIT = 20;
  localparam logic [1:0] TYPE_WRITE = 2'h2;
  localparam logic [1:0] TYPE_CMD = 2'h1;
  localparam logic [1:0] TYPE_SEQ = 2'h3;
  localparam logic [1:0] TYPE_READ = 2'h0;
  // result word layout
  localparam int ERR_HI = 10;
  localparam int ERR_LO = 6;
  localparam int FLAG_W = 6;
  localparam logic [3:0] RES_TAG_WRITE = 4'h1;
  localparam logic [3:0] RES_TAG_CMD = 4'h1;
  // bus interface error codes
  localparam logic [4:0] ERR_NONE = 5'h00;
  localparam logic [4:0] ERR_ERR_BEFORE_STB = 5'h01;
  localparam logic [4:0] ERR_ACK_BEFORE_STB = 5'h02;
  localparam logic [4:0] ERR_ERR_WAIT_ACK = 5'h03;
  localparam logic [4:0] ERR_ACK_TIMEOUT1 = 5'h04;
  localparam logic [4:0] ERR_ERR_WAIT_REL = 5'h05;
  localparam logic [4:0] ERR_ACK_TIMEOUT2 = 5'h06;
  localparam logic [4:0] ERR_BCAST = 5'h07;
  // analyser flag positions
  localparam int FLG_LOOP = 0;
  localparam int FLG_SEQ_FMT = 1;
  localparam int FLG_BC_FMT = 2;
  localparam int FLG_BC_OFF = 3;
  localparam int FLG_CHIP_FMT = 4;
  localparam int FLG_CHIP_OFF = 5;
  // front-end address fields
  localparam int BCAST_BIT = 18;
  localparam int BCAST_FLAG_BIT = 17;
  localparam int CARD_HI = 16;
  localparam int CARD_LO = 12;
  localparam int CARD_W = 5;
  localparam int CMD_HI = 4;
  localparam int CMD_LO = 0;
  localparam logic [4:0] EVT_READOUT_CODE = 5'h1A;
  // timing
  localparam int CLK_MHZ = 125;
  localparam int ACK_TIMEOUT_CYC = 40;
  localparam int CNT_W = 8;
  // direct command codes
  localparam logic [15:0] SC_GLOBAL_RESET = 16'h5300;
  localparam logic [15:0] SC_CARD_RESET = 16'h5301;
  localparam logic [15:0] SC_CTRL_RESET = 16'h5302;
  localparam logic [15:0] SC_CARD_RECONF = 16'h5303;
  localparam logic [15:0] SC_START_SEQ = 16'h5304;
  localparam logic [15:0] SC_ABORT_SEQ = 16'h5305;
  localparam logic [15:0] SC_SOFT_TRIG = 16'h5306;
  localparam logic [15:0] SC_CLR_ERR_STAT = 16'h5307;
  localparam logic [15:0] SC_CLR_RX_ERR = 16'h5308;
  localparam logic [15:0] SC_CLR_CNT = 16'h5309;
  localparam logic [15:0] SC_ARM_SYNC = 16'h530A;
  localparam logic [15:0] SC_SLOW_IRQ = 16'h5310;
  localparam logic [16:0] DL_GLOBAL_RESET = 17'h00002;
  localparam logic [16:0] DL_CARD_RESET = 17'h00008;
  localparam logic [16:0] DL_CTRL_RESET = 17'h00004;
  localparam logic [16:0] DL_CLR_ERR_STAT = 17'h10000;
  localparam int NUM_DCMD = 12;
  // direct command pulse positions
  localparam int DC_GRST = 0;
  localparam int DC_CRST = 1;
  localparam int DC_RRST = 2;
  localparam int DC_RECONF = 3;
  localparam int DC_START = 4;
  localparam int DC_ABORT = 5;
  localparam int DC_TRIG = 6;
  localparam int DC_CLR_ERR = 7;
  localparam int DC_CLR_RX = 8;
  localparam int DC_CLR_CNT = 9;
  localparam int DC_ARM = 10;
  localparam int DC_IRQ = 11;
endpackage

// File: design/dcmd_if.sv
`timescale 1ns/1ps
interface dcmd_if;
  logic [fe_seq_pkg::NUM_DCMD-1:0] pulse;
  modport src (output pulse);
  modport dst (input pulse);
endinterface

// File: design/direct_cmd_decoder.sv
`timescale 1ns/1ps
module direct_cmd_decoder (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic sc_cmd_valid_in,
  input wire logic [15:0] sc_cmd_code_in,
  input wire logic dl_cmd_valid_in,
  input wire logic [16:0] dl_cmd_value_in,
  dcmd_if.src cmd
);
  logic [fe_seq_pkg::NUM_DCMD-1:0] pulse_ff;
  logic [fe_seq_pkg::NUM_DCMD-1:0] nxt_pulse;

  always_comb begin
    nxt_pulse = '0;
    if (sc_cmd_valid_in) begin
      unique case (sc_cmd_code_in)
        fe_seq_pkg::SC_GLOBAL_RESET: nxt_pulse[fe_seq_pkg::DC_GRST] = 1'b1;
        fe_seq_pkg::SC_CARD_RESET: nxt_pulse[fe_seq_pkg::DC_CRST] = 1'b1;
        fe_seq_pkg::SC_CTRL_RESET: nxt_pulse[fe_seq_pkg::DC_RRST] = 1'b1;
        fe_seq_pkg::SC_CARD_RECONF: nxt_pulse[fe_seq_pkg::DC_RECONF] = 1'b1;
        fe_seq_pkg::SC_START_SEQ: nxt_pulse[fe_seq_pkg::DC_START] = 1'b1;
        fe_seq_pkg::SC_ABORT_SEQ: nxt_pulse[fe_seq_pkg::DC_ABORT] = 1'b1;
        fe_seq_pkg::SC_SOFT_TRIG: nxt_pulse[fe_seq_pkg::DC_TRIG] = 1'b1;
        fe_seq_pkg::SC_CLR_ERR_STAT: nxt_pulse[fe_seq_pkg::DC_CLR_ERR] = 1'b1;
        fe_seq_pkg::SC_CLR_RX_ERR: nxt_pulse[fe_seq_pkg::DC_CLR_RX] = 1'b1;
        fe_seq_pkg::SC_CLR_CNT: nxt_pulse[fe_seq_pkg::DC_CLR_CNT] = 1'b1;
        fe_seq_pkg::SC_ARM_SYNC: nxt_pulse[fe_seq_pkg::DC_ARM] = 1'b1;
        fe_seq_pkg::SC_SLOW_IRQ: nxt_pulse[fe_seq_pkg::DC_IRQ] = 1'b1;
        default: nxt_pulse = '0;
      endcase
    end
    if (dl_cmd_valid_in) begin
      // data-link values
      unique case (dl_cmd_value_in)
        fe_seq_pkg::DL_GLOBAL_RESET: nxt_pulse[fe_seq_pkg::DC_GRST] = 1'b1;
        fe_seq_pkg::DL_CARD_RESET: nxt_pulse[fe_seq_pkg::DC_CRST] = 1'b1;
        fe_seq_pkg::DL_CTRL_RESET: nxt_pulse[fe_seq_pkg::DC_RRST] = 1'b1;
        fe_seq_pkg::DL_CLR_ERR_STAT: nxt_pulse[fe_seq_pkg::DC_CLR_ERR] = 1'b1;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pulse_ff <= '0;
    end else begin
      pulse_ff <= nxt_pulse;
    end
  end

  assign cmd.pulse = pulse_ff;
endmodule

// File: design/frontend_write_cmd_sequencer.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - write instruction takes two words: parameters, then data
// - strobe rises only after programmable delay from driving the bus
// - ack must rise within 40 cycles of strobe, else timeout one
// - ack must fall within 40 cycles after seen, else timeout two
// - each write or command logs two result words; bit 20 marks failure
// - success: address word, then data word from instruction memory for a write, zero for a command
// - failure: second word holds error code 10:6 and flags 5:0
// - code 1 error before strobe, code 2 ack before strobe
// - code 3 error awaiting ack, code 4 first timeout
// - code 5 error awaiting release, code 6 second timeout
// - code 7 error line during broadcast write
// - flag 0 loop error, flag 1 bad sequencer format
// - flag 2 bad board-controller format, flag 4 bad chip format
// - flag 3 inactive board controller, flag 5 inactive chip addressed
// - command uses one word and the same strobe and ack sequence
// - event-readout command skips the ack assertion check
// - command failures use the same codes and flags as writes, except code 7
// - direct commands act at once and log nothing
// - slow-control port decodes three distinct reset codes
// - start and abort codes start and abort the sequencer
// - distinct codes clear rx error register and counters
// - abort stops the sequence and returns to idle
//////////////////////////////////////////////////////////////////////////////
module frontend_write_cmd_sequencer (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic sc_cmd_valid_in,
  input wire logic [15:0] sc_cmd_code_in,
  input wire logic dl_cmd_valid_in,
  input wire logic [16:0] dl_cmd_value_in,
  input wire logic [7:0] strobe_delay_in,
  input wire logic [31:0] active_card_list_in,
  input wire logic [21:0] imem_rdata_in,
  input wire logic ack_in,
  input wire logic chip_error_in,
  output logic [7:0] imem_addr_out,
  output logic rmem_we_out,
  output logic [7:0] rmem_addr_out,
  output logic [24:0] rmem_wdata_out,
  output logic bus_drive_out,
  output logic bus_write_out,
  output logic [19:0] bus_addr_out,
  output logic [19:0] bus_data_out,
  output logic cmd_strobe_out,
  output logic seq_busy_out,
  output logic global_reset_out,
  output logic card_reset_out,
  output logic ctrl_reset_out,
  output logic card_reconfigure_out,
  output logic soft_trigger_out,
  output logic clear_error_status_out,
  output logic clear_rx_error_out,
  output logic clear_counters_out,
  output logic arm_clock_sync_out,
  output logic slow_bus_irq_out
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_FETCH = 4'h1,
    ST_DECODE = 4'h3,
    ST_DATA = 4'h2,
    ST_DELAY = 4'h6,
    ST_WAIT_ACK = 4'h7,
    ST_WAIT_REL = 4'h5,
    ST_LOG1 = 4'h4,
    ST_LOG2 = 4'hC,
    ST_SKIP = 4'hD
  } seq_state_t;

  dcmd_if dcmd ();

  direct_cmd_decoder u_dec (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .sc_cmd_valid_in(sc_cmd_valid_in),
    .sc_cmd_code_in(sc_cmd_code_in),
    .dl_cmd_valid_in(dl_cmd_valid_in),
    .dl_cmd_value_in(dl_cmd_value_in),
    .cmd(dcmd)
  );

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] ack_sync_ff;
  logic [1:0] err_sync_ff;
  logic ack_s;
  logic err_s;
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ack_sync_ff <= 2'h0;
      err_sync_ff <= 2'h0;
    end else begin
      ack_sync_ff <= {ack_sync_ff[0], ack_in};
      err_sync_ff <= {err_sync_ff[0], chip_error_in};
    end
  end
  assign ack_s = ack_sync_ff[1];
  assign err_s = err_sync_ff[1];

  //////////////////////////////////////////////////////////////////////////////
  // instruction analysis
  function automatic logic [5:0] analyse(input logic [21:0] w, input logic [31:0] act);
    logic [5:0] f;
    logic [4:0] card;
    f = '0;
    card = w[fe_seq_pkg::CARD_HI:fe_seq_pkg::CARD_LO];
    if (w[fe_seq_pkg::TYPE_HI:fe_seq_pkg::TYPE_LO] == fe_seq_pkg::TYPE_SEQ)
      f[fe_seq_pkg::FLG_SEQ_FMT] = 1'b1;
    else if (w[fe_seq_pkg::BCAST_FLAG_BIT]) begin
      if (w[19]) f[fe_seq_pkg::FLG_BC_FMT] = 1'b1;
      if (!w[fe_seq_pkg::BCAST_BIT] && !act[card])
        f[fe_seq_pkg::FLG_BC_OFF] = 1'b1;
    end else begin
      if (w[19]) f[fe_seq_pkg::FLG_CHIP_FMT] = 1'b1;
      if (!w[fe_seq_pkg::BCAST_BIT] && !act[card])
        f[fe_seq_pkg::FLG_CHIP_OFF] = 1'b1;
    end
    return f;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // sequencer
  seq_state_t state_ff, nxt_state;
  logic [7:0] pc_ff, nxt_pc;
  logic [7:0] rptr_ff, nxt_rptr;
  logic [21:0] instr_ff, nxt_instr;
  logic [19:0] data_ff, nxt_data;
  logic [7:0] cnt_ff, nxt_cnt;
  logic [4:0] err_ff, nxt_err;
  logic [5:0] flags_ff, nxt_flags;
  logic is_write_ff, nxt_is_write;
  logic rmem_we_ff, nxt_rmem_we;
  logic [24:0] rmem_wdata_ff, nxt_rmem_wdata;
  logic [7:0] rmem_addr_ff, nxt_rmem_addr;
  logic drive_ff, nxt_drive;
  logic strobe_ff, nxt_strobe;
  logic no_ack_chk;
  logic failed;
  logic [3:0] tag;

  assign no_ack_chk = !is_write_ff &&
    (instr_ff[fe_seq_pkg::CMD_HI:fe_seq_pkg::CMD_LO] == fe_seq_pkg::EVT_READOUT_CODE);
  assign failed = (err_ff != fe_seq_pkg::ERR_NONE) || (flags_ff != 6'h00);
  assign tag = is_write_ff ? fe_seq_pkg::RES_TAG_WRITE : fe_seq_pkg::RES_TAG_CMD;

  always_comb begin
    nxt_state = state_ff;
    nxt_pc = pc_ff;
    nxt_rptr = rptr_ff;
    nxt_instr = instr_ff;
    nxt_data = data_ff;
    nxt_cnt = cnt_ff;
    nxt_err = err_ff;
    nxt_flags = flags_ff;
    nxt_is_write = is_write_ff;
    nxt_rmem_we = 1'b0;
    nxt_rmem_wdata = rmem_wdata_ff;
    nxt_rmem_addr = rmem_addr_ff;
    nxt_drive = drive_ff;
    nxt_strobe = strobe_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (dcmd.pulse[fe_seq_pkg::DC_START]) begin
          nxt_pc = 8'h00;
          nxt_rptr = 8'h00;
          nxt_state = ST_FETCH;
        end
      end
      ST_FETCH: nxt_state = ST_DECODE;
      ST_DECODE: begin
        nxt_instr = imem_rdata_in;
        nxt_err = fe_seq_pkg::ERR_NONE;
        nxt_flags = analyse(imem_rdata_in, active_card_list_in);
        nxt_is_write = imem_rdata_in[fe_seq_pkg::TYPE_HI:fe_seq_pkg::TYPE_LO] ==
          fe_seq_pkg::TYPE_WRITE;
        nxt_pc = pc_ff + 8'h01;
        unique case (imem_rdata_in[fe_seq_pkg::TYPE_HI:fe_seq_pkg::TYPE_LO])
          fe_seq_pkg::TYPE_WRITE: nxt_state = ST_DATA;
          fe_seq_pkg::TYPE_CMD: nxt_state = ST_DELAY;
          default: nxt_state = ST_SKIP;
        endcase
        nxt_cnt = 8'h00;
      end
      ST_DATA: begin
        nxt_pc = pc_ff + 8'h01;
        nxt_state = ST_DELAY;
      end
      ST_DELAY: begin
        if (flags_ff != 6'h00) begin
          nxt_state = ST_LOG1;
        end else begin
          nxt_drive = 1'b1;
          nxt_cnt = cnt_ff + 8'h01;
          // data word lands one cycle after pc moves
          if (is_write_ff && cnt_ff == 8'h00) begin
            nxt_data = imem_rdata_in[19:0];
          end
          if (err_s) begin
            nxt_err = fe_seq_pkg::ERR_ERR_BEFORE_STB;
            nxt_state = ST_LOG1;
          end else if (ack_s) begin
            nxt_err = fe_seq_pkg::ERR_ACK_BEFORE_STB;
            nxt_state = ST_LOG1;
          end else if (cnt_ff >= strobe_delay_in) begin
            nxt_strobe = 1'b1;
            nxt_cnt = 8'h00;
            nxt_state = no_ack_chk ? ST_WAIT_REL : ST_WAIT_ACK;
          end
        end
      end
      ST_WAIT_ACK: begin
        nxt_cnt = cnt_ff + 8'h01;
        if (err_s) begin
          nxt_err = (is_write_ff && instr_ff[fe_seq_pkg::BCAST_BIT]) ?
            fe_seq_pkg::ERR_BCAST : fe_seq_pkg::ERR_ERR_WAIT_ACK;
          nxt_state = ST_LOG1;
        end else if (ack_s) begin
          nxt_strobe = 1'b0;
          nxt_cnt = 8'h00;
          nxt_state = ST_WAIT_REL;
        end else if (cnt_ff == 8'(fe_seq_pkg::ACK_TIMEOUT_CYC - 1)) begin
          nxt_err = fe_seq_pkg::ERR_ACK_TIMEOUT1;
          nxt_state = ST_LOG1;
        end
      end
      ST_WAIT_REL: begin
        nxt_strobe = 1'b0;
        nxt_cnt = cnt_ff + 8'h01;
        if (err_s) begin
          nxt_err = (is_write_ff && instr_ff[fe_seq_pkg::BCAST_BIT]) ?
            fe_seq_pkg::ERR_BCAST : fe_seq_pkg::ERR_ERR_WAIT_REL;
          nxt_state = ST_LOG1;
        end else if (!ack_s) begin
          nxt_state = ST_LOG1;
        end else if (cnt_ff == 8'(fe_seq_pkg::ACK_TIMEOUT_CYC - 1)) begin
          nxt_err = fe_seq_pkg::ERR_ACK_TIMEOUT2;
          nxt_state = ST_LOG1;
        end
      end
      ST_LOG1: begin
        nxt_strobe = 1'b0;
        nxt_drive = 1'b0;
        nxt_rmem_we = 1'b1;
        nxt_rmem_addr = rptr_ff;
        nxt_rmem_wdata = {tag, failed, instr_ff[19:0]};
        nxt_rptr = rptr_ff + 8'h01;
        nxt_state = ST_LOG2;
      end
      ST_LOG2: begin
        nxt_rmem_we = 1'b1;
        nxt_rmem_addr = rptr_ff;
        if (failed)
          nxt_rmem_wdata = {tag, 1'b1, 9'h000, err_ff, flags_ff};
        else
          nxt_rmem_wdata = {tag, 1'b0, is_write_ff ? data_ff : 20'h00000};
        nxt_rptr = rptr_ff + 8'h01;
        nxt_state = ST_FETCH;
      end
      ST_SKIP: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
    if (dcmd.pulse[fe_seq_pkg::DC_ABORT] || dcmd.pulse[fe_seq_pkg::DC_RRST] ||
        dcmd.pulse[fe_seq_pkg::DC_GRST]) begin
      nxt_state = ST_IDLE;
      nxt_strobe = 1'b0;
      nxt_drive = 1'b0;
      nxt_rmem_we = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_ff <= ST_IDLE;
      pc_ff <= 8'h00;
      rptr_ff <= 8'h00;
      instr_ff <= 22'h000000;
      data_ff <= 20'h00000;
      cnt_ff <= 8'h00;
      err_ff <= 5'h00;
      flags_ff <= 6'h00;
      is_write_ff <= 1'b0;
      rmem_we_ff <= 1'b0;
      rmem_wdata_ff <= 25'h0000000;
      rmem_addr_ff <= 8'h00;
      drive_ff <= 1'b0;
      strobe_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pc_ff <= nxt_pc;
      rptr_ff <= nxt_rptr;
      instr_ff <= nxt_instr;
      data_ff <= nxt_data;
      cnt_ff <= nxt_cnt;
      err_ff <= nxt_err;
      flags_ff <= nxt_flags;
      is_write_ff <= nxt_is_write;
      rmem_we_ff <= nxt_rmem_we;
      rmem_wdata_ff <= nxt_rmem_wdata;
      rmem_addr_ff <= nxt_rmem_addr;
      drive_ff <= nxt_drive;
      strobe_ff <= nxt_strobe;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs
  logic [19:0] bus_addr_ff;
  logic [19:0] bus_data_ff;
  logic bus_write_ff;
  logic busy_ff;
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      bus_addr_ff <= 20'h00000;
      bus_data_ff <= 20'h00000;
      bus_write_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      bus_addr_ff <= nxt_drive ? nxt_instr[19:0] : 20'h00000;
      bus_data_ff <= (nxt_drive && nxt_is_write) ? nxt_data : 20'h00000;
      bus_write_ff <= nxt_drive && nxt_is_write;
      busy_ff <= nxt_state != ST_IDLE;
    end
  end

  assign imem_addr_out = pc_ff;
  assign rmem_we_out = rmem_we_ff;
  assign rmem_addr_out = rmem_addr_ff;
  assign rmem_wdata_out = rmem_wdata_ff;
  assign bus_drive_out = drive_ff;
  assign bus_write_out = bus_write_ff;
  assign bus_addr_out = bus_addr_ff;
  assign bus_data_out = bus_data_ff;
  assign cmd_strobe_out = strobe_ff;
  assign seq_busy_out = busy_ff;
  // direct commands leave result memory untouched
  assign global_reset_out = dcmd.pulse[fe_seq_pkg::DC_GRST];
  assign card_reset_out = dcmd.pulse[fe_seq_pkg::DC_CRST];
  assign ctrl_reset_out = dcmd.pulse[fe_seq_pkg::DC_RRST];
  assign card_reconfigure_out = dcmd.pulse[fe_seq_pkg::DC_RECONF];
  assign soft_trigger_out = dcmd.pulse[fe_seq_pkg::DC_TRIG];
  assign clear_error_status_out = dcmd.pulse[fe_seq_pkg::DC_CLR_ERR];
  assign clear_rx_error_out = dcmd.pulse[fe_seq_pkg::DC_CLR_RX];
  assign clear_counters_out = dcmd.pulse[fe_seq_pkg::DC_CLR_CNT];
  assign arm_clock_sync_out = dcmd.pulse[fe_seq_pkg::DC_ARM];
  assign slow_bus_irq_out = dcmd.pulse[fe_seq_pkg::DC_IRQ];
endmodule

// File: tb/fe_seq_assertions.sv
`timescale 1ns/1ps
module fe_seq_assertions (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic sc_cmd_valid_in,
  input wire logic [15:0] sc_cmd_code_in,
  input wire logic dl_cmd_valid_in,
  input wire logic [16:0] dl_cmd_value_in,
  input wire logic [7:0] strobe_delay_in,
  input wire logic rmem_we_out,
  input wire logic [7:0] rmem_addr_out,
  input wire logic [24:0] rmem_wdata_out,
  input wire logic bus_drive_out,
  input wire logic cmd_strobe_out,
  input wire logic seq_busy_out,
  input wire logic global_reset_out,
  input wire logic card_reset_out,
  input wire logic clear_rx_error_out,
  input wire logic clear_counters_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  //////////////////////////////////////////////////////////////////////////////
  property p_strobe_drive; cmd_strobe_out |-> bus_drive_out; endproperty
  a_strobe_drive: assert property (p_strobe_drive) else $error("strobe without drive");
  property p_strobe_late;
    $rose(cmd_strobe_out) && strobe_delay_in != 8'h00 |-> $past(bus_drive_out);
  endproperty
  a_strobe_late: assert property (p_strobe_late) else $error("strobe with drive");
  property p_ack_wait; $rose(cmd_strobe_out) |-> ##[1:44] !cmd_strobe_out; endproperty
  a_ack_wait: assert property (p_ack_wait) else $error("strobe too long");
  property p_rel_wait; $fell(cmd_strobe_out) |-> ##[0:45] !bus_drive_out; endproperty
  a_rel_wait: assert property (p_rel_wait) else $error("release wait too long");
  property p_pair; $rose(rmem_we_out) |=> rmem_we_out ##1 !rmem_we_out; endproperty
  a_pair: assert property (p_pair) else $error("result not two words");
  property p_tag; rmem_we_out |-> rmem_wdata_out[24:21] == 4'h1; endproperty
  a_tag: assert property (p_tag) else $error("bad result tag");
  property p_fail_word;
    $rose(rmem_we_out) && rmem_wdata_out[20] |=>
      rmem_wdata_out[20] && rmem_wdata_out[19:11] == 9'h000;
  endproperty
  a_fail_word: assert property (p_fail_word) else $error("bad failure word");
  property p_addr_step;
    $rose(rmem_we_out) |=> rmem_addr_out == $past(rmem_addr_out) + 8'h01;
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("result address step");
  property p_no_strobe_log; rmem_we_out |-> !cmd_strobe_out; endproperty
  a_no_strobe_log: assert property (p_no_strobe_log) else $error("strobe in log");
  property p_global_reset_cmd;
    sc_cmd_valid_in && sc_cmd_code_in == fe_seq_pkg::SC_GLOBAL_RESET |=> global_reset_out;
  endproperty
  a_global_reset_cmd: assert property (p_global_reset_cmd) else $error("global reset missing");
  property p_dl_card;
    dl_cmd_valid_in && dl_cmd_value_in == fe_seq_pkg::DL_CARD_RESET |=> card_reset_out;
  endproperty
  a_dl_card: assert property (p_dl_card) else $error("link card reset missing");
  property p_clr_rx;
    sc_cmd_valid_in && sc_cmd_code_in == fe_seq_pkg::SC_CLR_RX_ERR |=>
      clear_rx_error_out && !clear_counters_out;
  endproperty
  a_clr_rx: assert property (p_clr_rx) else $error("rx clear wrong");
  property p_start;
    sc_cmd_valid_in && sc_cmd_code_in == fe_seq_pkg::SC_START_SEQ && !seq_busy_out |->
      ##2 seq_busy_out;
  endproperty
  a_start: assert property (p_start) else $error("start ignored");
  property p_abort;
    sc_cmd_valid_in && sc_cmd_code_in == fe_seq_pkg::SC_ABORT_SEQ |->
      ##2 (!seq_busy_out && !cmd_strobe_out);
  endproperty
  a_abort: assert property (p_abort) else $error("abort not idle");
endmodule
bind frontend_write_cmd_sequencer fe_seq_assertions i_fe_seq_assertions (
  .sys_clk_in, .reset_in, .sc_cmd_valid_in, .sc_cmd_code_in, .dl_cmd_valid_in,
  .dl_cmd_value_in, .strobe_delay_in, .rmem_we_out, .rmem_addr_out, .rmem_wdata_out,
  .bus_drive_out, .cmd_strobe_out, .seq_busy_out, .global_reset_out, .card_reset_out,
  .clear_rx_error_out, .clear_counters_out);

// File: tb/card_model.sv
`timescale 1ns/1ps
// lines pulled low when the card does not drive them
module card_model (
  input wire logic sys_clk_in,
  input wire logic strobe_in,
  input wire logic drive_in,
  input wire logic [2:0] mode_in,
  output logic ack_out,
  output logic err_out
);
  logic [7:0] cnt_ff = 8'h00;
  initial ack_out = 1'b0;
  initial err_out = 1'b0;
  always @(posedge sys_clk_in) begin
    cnt_ff <= strobe_in ? cnt_ff + 8'h01 : 8'h00;
    case (mode_in)
      3'h0: ack_out <= strobe_in && cnt_ff >= 8'h02;
      3'h6: ack_out <= strobe_in && cnt_ff >= 8'h1E;
      3'h2: ack_out <= drive_in && (strobe_in || ack_out);
      3'h4: ack_out <= drive_in;
      default: ack_out <= 1'b0;
    endcase
    err_out <= (mode_in == 3'h3 && strobe_in) || (mode_in == 3'h5 && drive_in);
  end
endmodule

// File: tb/frontend_write_cmd_sequencer_bench.sv
`timescale 1ns/1ps
module frontend_write_cmd_sequencer_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sc_v = 1'b0;
  logic dl_v = 1'b0;
  logic [15:0] sc_code = 16'h0000;
  logic [16:0] dl_val = 17'h00000;
  logic [7:0] delay = 8'h08;
  logic [31:0] act = 32'hFFFFFFF7;
  logic [21:0] imem_rd = 22'h000000;
  logic [2:0] mode = 3'h0;
  logic [21:0] imem [256];
  logic [24:0] rm [256];
  logic [7:0] nw = 8'h00;
  logic [7:0] imem_addr, rmem_addr;
  logic rmem_we, drive, strobe, busy, ack, err;
  logic [24:0] rmem_wdata;
  logic [40:0] busv, capw;
  logic [9:0] pulses;
  int mismatches = 0;
  int num_checks = 0;
  logic [17:0] dk [15] = '{18'h05300, 18'h05301, 18'h05302, 18'h05303, 18'h05306,
    18'h05307, 18'h05308, 18'h05309, 18'h0530A, 18'h05310, 18'h20002, 18'h20008,
    18'h20004, 18'h30000, 18'h05311};
  logic [9:0] dexp [15] = '{10'h001, 10'h002, 10'h004, 10'h008, 10'h010, 10'h020,
    10'h040, 10'h080, 10'h100, 10'h200, 10'h001, 10'h002, 10'h004, 10'h020, 10'h000};
  logic [35:0] tc [14] = '{{22'h201003, 3'h6, 5'h00, 6'h00}, {22'h201003, 3'h1, 5'h04, 6'h00},
    {22'h201003, 3'h2, 5'h06, 6'h00}, {22'h201003, 3'h3, 5'h03, 6'h00},
    {22'h201003, 3'h4, 5'h02, 6'h00}, {22'h201003, 3'h5, 5'h01, 6'h00},
    {22'h241003, 3'h3, 5'h07, 6'h00}, {22'h101003, 3'h1, 5'h04, 6'h00},
    {22'h101003, 3'h5, 5'h01, 6'h00}, {22'h10101A, 3'h1, 5'h00, 6'h00},
    {22'h203003, 3'h0, 5'h00, 6'h20}, {22'h223003, 3'h0, 5'h00, 6'h08},
    {22'h281003, 3'h0, 5'h00, 6'h10}, {22'h2A1003, 3'h0, 5'h00, 6'h04}};
  //////////////////////////////////////////////////////////////////////////////
  always #4 clk = ~clk;
  always @(posedge clk) imem_rd <= imem[imem_addr];
  always @(posedge clk) if (strobe && busv[40]) capw <= busv;
  always @(posedge clk) begin
    if (rmem_we) begin
      rm[rmem_addr] <= rmem_wdata;
      nw <= nw + 8'h01;
    end
  end
  frontend_write_cmd_sequencer i_frontend_write_cmd_sequencer (
    .sys_clk_in(clk), .reset_in(rst), .sc_cmd_valid_in(sc_v), .sc_cmd_code_in(sc_code),
    .dl_cmd_valid_in(dl_v), .dl_cmd_value_in(dl_val), .strobe_delay_in(delay),
    .active_card_list_in(act), .imem_rdata_in(imem_rd), .ack_in(ack), .chip_error_in(err),
    .imem_addr_out(imem_addr), .rmem_we_out(rmem_we), .rmem_addr_out(rmem_addr),
    .rmem_wdata_out(rmem_wdata), .bus_drive_out(drive), .bus_write_out(busv[40]),
    .bus_addr_out(busv[39:20]), .bus_data_out(busv[19:0]), .cmd_strobe_out(strobe),
    .seq_busy_out(busy),
    .global_reset_out(pulses[0]), .card_reset_out(pulses[1]), .ctrl_reset_out(pulses[2]),
    .card_reconfigure_out(pulses[3]), .soft_trigger_out(pulses[4]),
    .clear_error_status_out(pulses[5]), .clear_rx_error_out(pulses[6]),
    .clear_counters_out(pulses[7]), .arm_clock_sync_out(pulses[8]),
    .slow_bus_irq_out(pulses[9]));
  card_model i_card_model (
    .sys_clk_in(clk), .strobe_in(strobe), .drive_in(drive), .mode_in(mode),
    .ack_out(ack), .err_out(err));
  //////////////////////////////////////////////////////////////////////////////
  task chk(input logic [24:0] got, input logic [24:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task results();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // one-cycle command on either port
  task cmd(input logic p, input logic [16:0] v);
    @(posedge clk);
    #1;
    sc_v = !p;
    dl_v = p;
    sc_code = v[15:0];
    dl_val = v;
    @(posedge clk);
    #1;
    sc_v = 1'b0;
    dl_v = 1'b0;
  endtask
  task run();
    int k;
    nw = 8'h00;
    cmd(1'b0, {1'b0, fe_seq_pkg::SC_START_SEQ});
    for (k = 0; k < 3000 && (k < 2 || busy !== 1'b0); k++) begin
      @(posedge clk);
      #1;
    end
    if (k == 3000) begin
      mismatches++;
      $display("BAD %0t sequence hang", $time);
    end
  endtask
  // single instruction: params, mode, expected code and flags
  task one(input logic [35:0] t);
    logic w;
    logic fl;
    w = t[35:34] == 2'h2;
    fl = t[10:0] != 11'h000;
    imem[0] = t[35:14];
    imem[1] = w ? 22'h0ABCDE : 22'h000000;
    imem[2] = 22'h000000;
    mode = t[13:11];
    run();
    chk({17'h0, nw}, 25'h0000002);
    chk(rm[0], {4'h1, fl, t[33:14]});
    chk(rm[1],
      fl ? {4'h1, 1'b1, 9'h000, t[10:0]} : {4'h1, 1'b0, w ? 20'hABCDE : 20'h0});
  endtask
  initial begin
    #200000;
    mismatches++;
    results();
  end
  initial begin
    foreach (imem[j]) imem[j] = 22'h000000;
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    for (int i = 0; i < 15; i++) begin
      cmd(dk[i][17], dk[i][16:0]);
      chk({15'h0, pulses}, {15'h0, dexp[i]});
    end
    chk({17'h0, nw}, 25'h0000000);
    imem[0] = 22'h205123;
    imem[1] = 22'h0ABCDE;
    imem[2] = 22'h102007;
    imem[3] = 22'h000000;
    run();
    chk({17'h0, nw}, 25'h0000004);
    chk(rm[0], {4'h1, 1'b0, 20'h05123});
    chk(rm[1], {4'h1, 1'b0, 20'hABCDE});
    chk(rm[2], {4'h1, 1'b0, 20'h02007});
    chk(rm[3], {4'h1, 1'b0, 20'h00000});
    chk({4'h0, capw[40:20]}, {4'h0, 1'b1, 20'h05123});
    chk({5'h0, capw[19:0]}, {5'h0, 20'hABCDE});
    for (int i = 0; i < 14; i++) begin
      one(tc[i]);
    end
    imem[0] = 22'h201003;
    mode = 3'h1;
    nw = 8'h00;
    cmd(1'b0, {1'b0, fe_seq_pkg::SC_START_SEQ});
    repeat (15) @(posedge clk);
    cmd(1'b0, {1'b0, fe_seq_pkg::SC_ABORT_SEQ});
    @(posedge clk);
    #1;
    chk({22'h0, busy, strobe, drive}, 25'h0000000);
    chk({17'h0, nw}, 25'h0000000);
    results();
  end
endmodule
